// ==== ssc_pkg.sv ====
// Shared constants, frame and flag layouts for the safety self-test control block.
// Assumes a single 250 MHz clock and an SPI controller driving 24-bit frames.
`default_nettype none

package ssc_pkg;

	// Frame layout: command byte, data byte, checksum byte, most significant bit first.
	localparam int FRAME_BITS = 24;
	localparam int CRC_COVER_BITS = 16;
	localparam int CMD_WRITE_POS = 7;
	localparam logic [4:0] FRAME_LEN = 5'h18;
	localparam logic [4:0] CRC_COVER_LEN = 5'h10;
	localparam logic [4:0] BITCNT_MAX = 5'h1F;
	localparam logic [4:0] BITCNT_ZERO = 5'h00;

	// Checksum generator; polynomial and seed are plain defaults.
	localparam logic [7:0] CRC_POLY = 8'h1D;
	localparam logic [7:0] CRC_INIT = 8'hFF;

	// Register addresses carried in the low seven bits of the command byte.
	localparam logic [6:0] ADDR_XFER_STATUS = 7'h20;
	localparam logic [6:0] ADDR_ANALOG_CTRL = 7'h21;
	localparam logic [6:0] ADDR_LOGIC_CTRL = 7'h22;
	localparam logic [6:0] ADDR_ANALOG_RESULT = 7'h23;

	// Reset values and writable field masks.
	localparam logic [7:0] REG_RESET = 8'h00;
	localparam logic [7:0] FILL_BYTE = 8'h00;
	localparam logic [7:0] ANALOG_CTRL_MASK = 8'h0F;
	localparam logic [7:0] LOGIC_CTRL_MASK = 8'h3F;
	localparam int LOGIC_RUN_POS = 0;
	localparam logic [2:0] PIN_SYNC_RESET = 3'h2;

	// Transfer error events, bit 3 down to bit 0 of the status register.
	typedef struct packed {
		logic rx_frame_checksum_error;
		logic clock_high_at_select_fall;
		logic clock_high_at_select_rise;
		logic reset_terminated;
	} ssc_xfer_ev_t;

	typedef struct packed {
		logic [7:0] cmd;
		logic [7:0] data;
		logic [7:0] crc;
	} ssc_frame_t;

	typedef enum logic [3:0] {
		ST_IDLE = 4'b0001,
		ST_FRAME = 4'b0010,
		ST_ABORT = 4'b0100,
		ST_END = 4'b1000
	} ssc_state_t;

	function automatic logic [7:0] ssc_crc8_step(input logic [7:0] crc, input logic din);
		logic [7:0] shifted;
		shifted = {crc[6:0], 1'b0};
		return (crc[7] ^ din) ? (shifted ^ CRC_POLY) : shifted;
	endfunction

endpackage

`default_nettype wire

// ==== ssc_pin_sync.sv ====
// Three-stage synchroniser with agreement filter for asynchronous pins.
// Assumes inputs arrive from outside the clock domain.
`timescale 1ns/1ps
`default_nettype none

module ssc_pin_sync #(
	parameter int WIDTH = 3,
	parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic [WIDTH-1:0] pin_in,
	output var logic [WIDTH-1:0] stable_reg
);

	logic [WIDTH-1:0] s1_reg;
	logic [WIDTH-1:0] s2_reg;
	logic [WIDTH-1:0] s3_reg;
	logic [WIDTH-1:0] stable_next;

	// A bit changes only once the second and third stages agree.
	always_comb begin
		stable_next = stable_reg;
		for (int i = 0; i < WIDTH; i++) begin
			if (s2_reg[i] == s3_reg[i]) begin
				stable_next[i] = s3_reg[i];
			end
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			s1_reg <= RESET_VAL;
			s2_reg <= RESET_VAL;
			s3_reg <= RESET_VAL;
			stable_reg <= RESET_VAL;
		end else begin
			s1_reg <= pin_in;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			stable_reg <= stable_next;
		end
	end

endmodule // ssc_pin_sync

`default_nettype wire

// ==== ssc_flag_bank.sv ====
// Sticky flags cleared by a read, where a new event wins over the clear.
// Assumes set and clear pulses come from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none

module ssc_flag_bank #(
	parameter int WIDTH = 8
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic [WIDTH-1:0] set_vec,
	input wire logic read_clear,
	output var logic [WIDTH-1:0] flags_reg
);

	logic [WIDTH-1:0] flags_next;

	// A flag whose condition is still present in the clearing cycle stays set.
	always_comb begin
		flags_next = set_vec | (read_clear ? '0 : flags_reg);
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			flags_reg <= '0;
		end else begin
			flags_reg <= flags_next;
		end
	end

endmodule // ssc_flag_bank

`default_nettype wire

// ==== ssc_selftest_ctrl.sv ====
// Safety self-test control and SPI transfer error status, reached over SPI.
// Assumes the test engines pulse their done inputs once per completed run.
`timescale 1ns/1ps
`default_nettype none

module ssc_selftest_ctrl
	import ssc_pkg::*;
(
	input wire logic clock,
	input wire logic rst,
	input wire logic spi_sclk,
	input wire logic spi_cs_n,
	input wire logic spi_sdi,
	output var logic spi_sdo,
	output var logic spi_sdo_oe,
	input wire logic device_in_reset_state,
	input wire logic selftest_write_lock,
	input wire logic scheduler_active_enabled,
	input wire logic logic_run_state_ok,
	input wire logic [3:0] analog_test_done,
	input wire logic [3:0] analog_test_fail,
	input wire logic [5:0] logic_check_done,
	output var logic [7:0] analog_selftest_control,
	output var logic [3:0] analog_test_launch,
	output var logic [7:0] logic_selftest_control,
	output var logic [5:0] logic_test_launch,
	output var logic [7:0] serial_transfer_error_status,
	output var logic [7:0] analog_test_result_status
);

	logic [2:0] pins_s;
	logic sclk_s;
	logic cs_n_s;
	logic sdi_s;

	ssc_pin_sync #(
		.WIDTH(3),
		.RESET_VAL(PIN_SYNC_RESET)
	) u_pin_sync (
		.clock(clock),
		.rst(rst),
		.pin_in({spi_sclk, spi_cs_n, spi_sdi}),
		.stable_reg(pins_s)
	);

	assign sclk_s = pins_s[2];
	assign cs_n_s = pins_s[1];
	assign sdi_s = pins_s[0];

	// Frame engine state.
	ssc_state_t state_reg, state_next;
	logic [4:0] bitcnt_reg, bitcnt_next;
	ssc_frame_t rx_reg, rx_next;
	logic [7:0] crc_reg, crc_next;
	logic [FRAME_BITS-1:0] tx_reg, tx_next;
	logic sclk_d_reg, sclk_d_next;
	logic cs_d_reg, cs_d_next;
	logic fall_err_reg, fall_err_next;
	logic rise_err_reg, rise_err_next;
	logic sdo_next;
	logic sdo_oe_next;

	// Register state.
	logic [7:0] analog_ctrl_reg, analog_ctrl_next;
	logic [7:0] logic_ctrl_reg, logic_ctrl_next;
	logic [3:0] analog_launch_reg, analog_launch_next;
	logic [5:0] logic_launch_reg, logic_launch_next;
	logic [7:0] rd_data_reg, rd_data_next;

	logic cs_fall;
	logic cs_rise;
	logic sclk_rise;
	logic sclk_fall;
	logic frame_full;
	logic frame_ok;
	logic end_valid;
	logic is_write;
	logic [6:0] addr;
	logic [7:0] wdata;
	ssc_xfer_ev_t xfer_ev;
	logic xfer_read_clear;
	logic result_read_clear;
	logic [7:0] xfer_flags;
	logic [7:0] result_flags;

	assign cs_fall = cs_d_reg & ~cs_n_s;
	assign cs_rise = ~cs_d_reg & cs_n_s;
	assign sclk_rise = ~sclk_d_reg & sclk_s;
	assign sclk_fall = sclk_d_reg & ~sclk_s;
	assign frame_full = (bitcnt_reg == FRAME_LEN);
	assign frame_ok = frame_full && (crc_reg == rx_reg.crc);
	assign end_valid = (state_reg == ST_END) && frame_ok;
	assign is_write = rx_reg.cmd[CMD_WRITE_POS];
	assign addr = rx_reg.cmd[6:0];
	assign wdata = rx_reg.data;

	always_comb begin
		state_next = state_reg;
		bitcnt_next = bitcnt_reg;
		rx_next = rx_reg;
		crc_next = crc_reg;
		tx_next = tx_reg;
		sclk_d_next = sclk_s;
		cs_d_next = cs_n_s;
		fall_err_next = fall_err_reg;
		rise_err_next = rise_err_reg;
		xfer_ev = '0;
		case (state_reg)
			ST_IDLE: begin
				if (cs_fall) begin
					state_next = ST_FRAME;
					bitcnt_next = BITCNT_ZERO;
					crc_next = CRC_INIT;
					// The previous frame's read answer leaves first.
					tx_next = {rd_data_reg, FILL_BYTE, FILL_BYTE};
					fall_err_next = sclk_s;
					rise_err_next = 1'b0;
				end
			end
			ST_FRAME: begin
				if (device_in_reset_state) begin
					xfer_ev.reset_terminated = 1'b1;
					state_next = ST_ABORT;
				end else if (cs_rise) begin
					rise_err_next = sclk_s;
					state_next = ST_END;
				end else begin
					if (sclk_rise) begin
						rx_next = {rx_reg[FRAME_BITS-2:0], sdi_s};
						if (bitcnt_reg != BITCNT_MAX) begin
							bitcnt_next = 5'(bitcnt_reg + 5'h01);
						end
						if (bitcnt_reg < CRC_COVER_LEN) begin
							crc_next = ssc_crc8_step(crc_reg, sdi_s);
						end
					end
					if (sclk_fall && (bitcnt_reg != BITCNT_ZERO)) begin
						tx_next = {tx_reg[FRAME_BITS-2:0], 1'b0};
					end
				end
			end
			ST_ABORT: begin
				// The aborted frame is never executed; wait for select to rise.
				if (cs_n_s) begin
					state_next = ST_IDLE;
				end
			end
			ST_END: begin
				xfer_ev.rx_frame_checksum_error = frame_full && !frame_ok;
				xfer_ev.clock_high_at_select_fall = fall_err_reg;
				xfer_ev.clock_high_at_select_rise = rise_err_reg;
				state_next = ST_IDLE;
			end
			default: begin
				state_next = ST_IDLE;
			end
		endcase
		sdo_oe_next = ~cs_n_s;
		sdo_next = (~cs_n_s) & tx_reg[FRAME_BITS-1];
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			state_reg <= ST_IDLE;
			bitcnt_reg <= BITCNT_ZERO;
			rx_reg <= '0;
			crc_reg <= CRC_INIT;
			tx_reg <= '0;
			sclk_d_reg <= 1'b0;
			cs_d_reg <= 1'b1;
			fall_err_reg <= 1'b0;
			rise_err_reg <= 1'b0;
			spi_sdo <= 1'b0;
			spi_sdo_oe <= 1'b0;
		end else begin
			state_reg <= state_next;
			bitcnt_reg <= bitcnt_next;
			rx_reg <= rx_next;
			crc_reg <= crc_next;
			tx_reg <= tx_next;
			sclk_d_reg <= sclk_d_next;
			cs_d_reg <= cs_d_next;
			fall_err_reg <= fall_err_next;
			rise_err_reg <= rise_err_next;
			spi_sdo <= sdo_next;
			spi_sdo_oe <= sdo_oe_next;
		end
	end

	ssc_flag_bank #(
		.WIDTH(8)
	) u_xfer_flags (
		.clock(clock),
		.rst(rst),
		.set_vec({4'h0, xfer_ev}),
		.read_clear(xfer_read_clear),
		.flags_reg(xfer_flags)
	);

	ssc_flag_bank #(
		.WIDTH(8)
	) u_result_flags (
		.clock(clock),
		.rst(rst),
		.set_vec({analog_test_done & analog_test_fail, analog_test_done}),
		.read_clear(result_read_clear),
		.flags_reg(result_flags)
	);

	assign serial_transfer_error_status = xfer_flags;
	assign analog_test_result_status = result_flags;

	always_comb begin
		analog_ctrl_next = analog_ctrl_reg;
		logic_ctrl_next = logic_ctrl_reg;
		analog_launch_next = 4'h0;
		logic_launch_next = 6'h00;
		rd_data_next = rd_data_reg;
		xfer_read_clear = 1'b0;
		result_read_clear = 1'b0;
		if (device_in_reset_state) begin
			analog_ctrl_next = REG_RESET;
			logic_ctrl_next = REG_RESET;
		end else begin
			if (!scheduler_active_enabled) begin
				analog_ctrl_next = analog_ctrl_reg & ~{4'h0, analog_test_done};
			end
			logic_ctrl_next = logic_ctrl_reg & ~{2'b00, logic_check_done};
			if (end_valid && is_write && !selftest_write_lock) begin
				if (addr == ADDR_ANALOG_CTRL) begin
					analog_ctrl_next = wdata & ANALOG_CTRL_MASK;
					analog_launch_next = wdata[3:0];
				end else if (addr == ADDR_LOGIC_CTRL) begin
					logic_ctrl_next = wdata & LOGIC_CTRL_MASK;
					logic_launch_next = wdata[5:0];
					if (!logic_run_state_ok) begin
						logic_ctrl_next[LOGIC_RUN_POS] = logic_ctrl_reg[LOGIC_RUN_POS];
						logic_launch_next[LOGIC_RUN_POS] = 1'b0;
					end
				end
			end
		end
		if (end_valid && !is_write) begin
			if (addr == ADDR_XFER_STATUS) begin
				rd_data_next = xfer_flags;
				xfer_read_clear = 1'b1;
			end else if (addr == ADDR_ANALOG_CTRL) begin
				rd_data_next = analog_ctrl_reg;
			end else if (addr == ADDR_LOGIC_CTRL) begin
				rd_data_next = logic_ctrl_reg;
			end else if (addr == ADDR_ANALOG_RESULT) begin
				rd_data_next = result_flags;
				result_read_clear = 1'b1;
			end else begin
				rd_data_next = FILL_BYTE;
			end
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			analog_ctrl_reg <= REG_RESET;
			logic_ctrl_reg <= REG_RESET;
			analog_launch_reg <= 4'h0;
			logic_launch_reg <= 6'h00;
			rd_data_reg <= REG_RESET;
		end else begin
			analog_ctrl_reg <= analog_ctrl_next;
			logic_ctrl_reg <= logic_ctrl_next;
			analog_launch_reg <= analog_launch_next;
			logic_launch_reg <= logic_launch_next;
			rd_data_reg <= rd_data_next;
		end
	end

	assign analog_selftest_control = analog_ctrl_reg;
	assign logic_selftest_control = logic_ctrl_reg;
	assign analog_test_launch = analog_launch_reg;
	assign logic_test_launch = logic_launch_reg;

endmodule // ssc_selftest_ctrl

`default_nettype wire

// ==== ssc_props.sv ====
// Port-level checker for the self-test control block.
// Assumes one clock domain with a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module ssc_props (
	input wire logic clock,
	input wire logic rst,
	input wire logic spi_cs_n,
	input wire logic device_in_reset_state,
	input wire logic selftest_write_lock,
	input wire logic scheduler_active_enabled,
	input wire logic [3:0] analog_test_done,
	input wire logic [3:0] analog_test_fail,
	input wire logic [5:0] logic_check_done,
	input wire logic [7:0] analog_selftest_control,
	input wire logic [3:0] analog_test_launch,
	input wire logic [7:0] logic_selftest_control,
	input wire logic [5:0] logic_test_launch,
	input wire logic [7:0] serial_transfer_error_status,
	input wire logic [7:0] analog_test_result_status
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);
	a_rsv_zero: assert property (analog_selftest_control[7:4] == 4'h0 && logic_selftest_control[7:6] == 2'h0)
		else $error("reserved control bits set");
	a_reset_init: assert property ($fell(rst) |-> analog_selftest_control == 8'h00 && logic_selftest_control == 8'h00)
		else $error("control not initial after reset");
	a_state_clear: assert property (device_in_reset_state [*2] |=> analog_selftest_control == 8'h00 && logic_selftest_control == 8'h00)
		else $error("control kept in reset state");
	a_lock_blocks: assert property (selftest_write_lock && $past(selftest_write_lock) |-> analog_test_launch == 4'h0 && logic_test_launch == 6'h00)
		else $error("launch while locked");
	a_launch_bit: assert property (analog_test_launch != 4'h0 |-> (analog_selftest_control[3:0] & analog_test_launch) == analog_test_launch)
		else $error("launch without start bit");
	a_done_result: assert property (analog_test_done != 4'h0 |=> (analog_test_result_status[3:0] & $past(analog_test_done)) == $past(analog_test_done) && (analog_test_result_status[7:4] & $past(analog_test_done & analog_test_fail)) == $past(analog_test_done & analog_test_fail))
		else $error("result bits not set");
	a_self_clear: assert property (analog_test_done[0] && !scheduler_active_enabled |=> !analog_selftest_control[0] || analog_test_launch[0])
		else $error("start bit not cleared");
	a_sched_keep: assert property (analog_test_done[1] && scheduler_active_enabled && analog_selftest_control[1] && !device_in_reset_state |=> analog_selftest_control[1])
		else $error("start bit cleared under scheduler");
	a_logic_launch: assert property (logic_test_launch != 6'h00 |-> (logic_selftest_control[5:0] & logic_test_launch) == logic_test_launch)
		else $error("logic launch without bit");
	a_check_clear: assert property (logic_check_done[1] |=> !logic_selftest_control[1] || logic_test_launch[1])
		else $error("check bit not cleared");
	a_flag_sticky: assert property ((|($past(serial_transfer_error_status) & ~serial_transfer_error_status)) |-> spi_cs_n)
		else $error("flag dropped mid-frame");
	c_launch: cover property (analog_test_launch != 4'h0);
	c_flags: cover property (serial_transfer_error_status[3:0] == 4'hF);
	c_sched: cover property (analog_test_done[1] && scheduler_active_enabled);
endmodule // ssc_props
`default_nettype wire

// ==== ssc_host_model.sv ====
// Host controller model driving SPI mode 0 frames into the block.
// Assumes the testbench calls xfer and that the link is idle between calls.
`timescale 1ns/1ps
`default_nettype none
module ssc_host_model (
	input wire logic clock,
	input wire logic spi_sdo,
	output var logic spi_sclk,
	output var logic spi_cs_n,
	output var logic spi_sdi
);
	initial begin
		spi_sclk = 1'b0;
		spi_cs_n = 1'b1;
		spi_sdi = 1'b0;
	end
	task automatic wc(input int k);
		repeat (k) @(negedge clock);
	endtask
	function automatic logic [23:0] mk(input logic [7:0] c, input logic [7:0] d);
		logic [7:0] r;
		logic [15:0] v;
		r = 8'hFF;
		v = {c, d};
		for (int i = 15; i >= 0; i--) begin
			r = (r[7] ^ v[i]) ? ({r[6:0], 1'b0} ^ 8'h1D) : {r[6:0], 1'b0};
		end
		return {v, r};
	endfunction
	// Clock errors are forced only when the caller asks, by ef or er.
	task automatic xfer(input logic [23:0] f, input int n, input bit ef, input bit er,
			output logic [7:0] rd);
		logic [23:0] s;
		s = '0;
		spi_sclk = ef;
		wc(6);
		spi_cs_n = 1'b0;
		wc(6);
		spi_sclk = 1'b0;
		for (int i = 0; i < n; i++) begin
			spi_sdi = f[23 - (i % 24)];
			wc(5);
			spi_sclk = 1'b1;
			wc(5);
			// The device answers a few clocks after each falling edge, so the
			// bit is taken at the end of the high phase, where it has settled.
			s = {s[22:0], spi_sdo};
			// A clock error at the select rise keeps the last high phase.
			spi_sclk = (i == n - 1) ? er : 1'b0;
		end
		wc(6);
		spi_cs_n = 1'b1;
		wc(6);
		spi_sclk = 1'b0;
		// A released data line must not keep its last value.
		spi_sdi = ~spi_sdi;
		rd = s[23:16];
		wc(8);
	endtask
endmodule // ssc_host_model
`default_nettype wire

// ==== ssc_selftest_ctrl_tb_top.sv ====
// Self-checking bench for the self-test control block.
// Assumes the host model in ssc_host_model.sv and the checker in ssc_props.sv.
`timescale 1ns/1ps
`default_nettype none
module ssc_selftest_ctrl_tb_top;
	import ssc_pkg::*;
	logic clock = 1'b0, rst = 1'b1, sclk, cs_n, sdi, sdo, oe;
	logic dirs = 0, lock = 0, sched = 0, run_ok = 0;
	logic [3:0] a_done = 0, a_fail = 0, a_go, an_l = 0;
	logic [5:0] l_done = 0, l_go, lg_l = 0;
	logic [7:0] a_ctl, l_ctl, st, res, rd;
	int err_total = 0, num_checks = 0;
	always #2 clock = ~clock;
	always @(posedge clock) begin
		an_l <= an_l | a_go;
		lg_l <= lg_l | l_go;
	end
	ssc_host_model i_host (.clock(clock), .spi_sdo(sdo), .spi_sclk(sclk), .spi_cs_n(cs_n),
		.spi_sdi(sdi));
	ssc_selftest_ctrl i_dut (.clock(clock), .rst(rst), .spi_sclk(sclk), .spi_cs_n(cs_n),
		.spi_sdi(sdi), .spi_sdo(sdo), .spi_sdo_oe(oe), .device_in_reset_state(dirs),
		.selftest_write_lock(lock), .scheduler_active_enabled(sched),
		.logic_run_state_ok(run_ok), .analog_test_done(a_done), .analog_test_fail(a_fail),
		.logic_check_done(l_done), .analog_selftest_control(a_ctl), .analog_test_launch(a_go),
		.logic_selftest_control(l_ctl), .logic_test_launch(l_go),
		.serial_transfer_error_status(st), .analog_test_result_status(res));
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		num_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("mismatch at %0t: got %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic test_done();
		$display("checks %0d errors %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		i_host.xfer(i_host.mk({1'b1, a}, d), 24, 0, 0, rd);
	endtask
	task automatic t_control();
		chk(a_ctl, 8'h00);
		chk({7'h00, oe}, 8'h00);
		wr(ADDR_ANALOG_CTRL, 8'hFF);
		chk(a_ctl, 8'h0F);
		chk({4'h0, an_l}, 8'h0F);
		wr(ADDR_LOGIC_CTRL, 8'hFF);
		chk(l_ctl, 8'h3E);
		chk({2'h0, lg_l}, 8'h3E);
		@(negedge clock) l_done = 6'h3E;
		@(negedge clock) l_done = 6'h00;
		@(negedge clock) chk(l_ctl, 8'h00);
		run_ok = 1'b1;
		wr(ADDR_LOGIC_CTRL, 8'h21);
		chk({2'h0, lg_l}, 8'h3F);
	endtask
	task automatic t_analog();
		@(negedge clock) {a_done, a_fail} = 8'h54;
		@(negedge clock) {a_done, a_fail} = 8'h00;
		@(negedge clock) chk(a_ctl, 8'h0A);
		chk(res, 8'h45);
		sched = 1'b1;
		@(negedge clock) a_done = 4'h2;
		@(negedge clock) a_done = 4'h0;
		@(negedge clock) chk(a_ctl, 8'h0A);
		lock = 1'b1;
		wr(ADDR_ANALOG_CTRL, 8'h00);
		chk(a_ctl, 8'h0A);
		lock = 1'b0;
		@(negedge clock) dirs = 1'b1;
		repeat (3) @(negedge clock);
		dirs = 1'b0;
		chk(a_ctl | l_ctl, 8'h00);
	endtask
	task automatic t_errors();
		i_host.xfer(24'h20_0000, 24, 0, 0, rd);
		chk(st, 8'h08);
		i_host.xfer(i_host.mk(8'h20, 8'h00) ^ 24'h00_0100, 24, 1, 0, rd);
		chk(st, 8'h0C);
		i_host.xfer(i_host.mk(8'h7F, 8'h00), 24, 0, 1, rd);
		chk(st, 8'h0E);
		fork
			i_host.xfer(i_host.mk(8'h7F, 8'h00), 24, 0, 0, rd);
			begin
				repeat (60) @(negedge clock);
				chk({7'h00, oe}, 8'h01);
				dirs = 1'b1;
				repeat (3) @(negedge clock);
				dirs = 1'b0;
			end
		join
		chk(st, 8'h0F);
		i_host.xfer(i_host.mk({1'b0, ADDR_XFER_STATUS}, 8'h00), 24, 0, 0, rd);
		chk(st, 8'h00);
		i_host.xfer(i_host.mk({1'b0, ADDR_ANALOG_RESULT}, 8'h00), 24, 0, 0, rd);
		chk(rd, 8'h0F);
		chk(res, 8'h00);
		i_host.xfer(i_host.mk(8'h7F, 8'h00), 24, 0, 0, rd);
		chk(rd, 8'h47);
	endtask
	initial begin
		repeat (8) @(negedge clock);
		rst = 1'b0;
		repeat (6) @(negedge clock);
		t_control();
		t_analog();
		t_errors();
		test_done();
	end
	initial begin
		repeat (20000) @(posedge clock);
		err_total++;
		test_done();
	end
endmodule // ssc_selftest_ctrl_tb_top
bind ssc_selftest_ctrl ssc_props i_props (.*);
`default_nettype wire
